// ===== rtl/dmrt_pkg.sv
`default_nettype none
package dmrt_pkg;
  // ----------------------------------------------------------------
  // Register offsets, one aligned word each; printed offsets are
  // register indices, the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MON_SEL    = 8'h2B;
  localparam logic [7:0] IDX_OPEN_QUEUE = 8'h2C;
  localparam logic [7:0] IDX_SAMPLE_MON = 8'h2D;
  localparam logic [7:0] IDX_OVER_MON   = 8'h2E;
  localparam logic [7:0] IDX_IDENT      = 8'h2F;
  localparam logic [9:0] ADDR_MON_SEL    = {IDX_MON_SEL, 2'b00};
  localparam logic [9:0] ADDR_OPEN_QUEUE = {IDX_OPEN_QUEUE, 2'b00};
  localparam logic [9:0] ADDR_SAMPLE_MON = {IDX_SAMPLE_MON, 2'b00};
  localparam logic [9:0] ADDR_OVER_MON   = {IDX_OVER_MON, 2'b00};
  localparam logic [9:0] ADDR_IDENT      = {IDX_IDENT, 2'b00};

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CH7_SEL_LSB     = 0;
  localparam int         CH8_SEL_LSB     = 3;
  localparam int         PART_CODE_LSB   = 4;
  localparam logic [7:0] MON_SEL_RESET   = 8'h00;
  localparam logic [7:0] OPEN_Q_RESET    = 8'h00;
  localparam logic [7:0] CLK_MON_RESET   = 8'h00;
  localparam logic [7:0] OPEN_Q_MANUAL   = 8'h01;

  // ----------------------------------------------------------------
  // Monitored clock timing
  // ----------------------------------------------------------------
  localparam int         CLK_MON_DIVIDE  = 64;
  localparam logic [5:0] PRESCALE_LAST   = 6'h3F;

  // ----------------------------------------------------------------
  // Diagnostic selector codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DMRT_SEL_INPUT_PIN     = 3'h0,
    DMRT_SEL_TEMP_SENSOR   = 3'h1,
    DMRT_SEL_REF_2V5       = 3'h2,
    DMRT_SEL_ANALOG_LDO    = 3'h3,
    DMRT_SEL_DIGITAL_LDO   = 3'h4,
    DMRT_SEL_IO_SUPPLY     = 3'h5,
    DMRT_SEL_ANALOG_GROUND = 3'h6,
    DMRT_SEL_ANALOG_SUPPLY = 3'h7
  } dmrt_sel_t;

  typedef enum logic [1:0] {
    DMRT_OPEN_OFF    = 2'h0,
    DMRT_OPEN_MANUAL = 2'h1,
    DMRT_OPEN_AUTO   = 2'h3
  } dmrt_open_mode_t;
endpackage
`default_nettype wire

// ===== rtl/dmrt_regs.sv
// Operation
// - Channel 7 selector in bits 2:0, reset 0, code 0 means input pin.
// - Codes 1..7 route to temp, 2.5V ref, LDOs, IO supply, ground, supply.
// - Channel 8 selector in bits 5:3, same encoding as channel 7.
// - Open-circuit queue register, RW, reset 0; value 1 means manual mode.
// - Queue above one: automatic mode, switch after that many unchanged codes.
// - Sample clock monitor counts once per 64 sample clock cycles.
// - Oversample clock monitor counts once per 64 oversample clock cycles.
// - Read-only identification: part code 7:4, revision 3:0, writes ignored.
// - Both selectors share one register, reset 0, bits 7:6 read zero.
`timescale 1ns/10ps
`default_nettype none
module dmrt_regs #(
  parameter logic [3:0] PART_CODE = 4'hA,  // Arbitrary value
  parameter logic [3:0] SILICON_REV = 4'h5 // Arbitrary value
) (
  input  wire  logic       ref_clk,
  input  wire  logic       rst_b,
  input  wire  logic       clk_en,
  input  wire  logic       psel,
  input  wire  logic       penable,
  input  wire  logic       pwrite,
  input  wire  logic [9:0] paddr,
  input  wire  logic [31:0] pwdata,
  input  wire  logic [3:0] pstrb,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire  logic       sample_clk_pin,
  input  wire  logic       oversample_clk_pin,
  input  wire  logic       code_unchanged,
  output logic       [2:0] channel7_monitor_select,
  output logic       [2:0] channel8_monitor_select,
  output logic       [1:0] open_detect_mode,
  output logic             common_mode_switch
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       wr_en;
  logic       rd_en;
  logic       addr_hit;
  logic [7:0] rd_word;
  logic [7:0] mon_sel_reg;
  logic [7:0] open_queue_reg;
  logic [7:0] sample_cnt_reg;
  logic [7:0] over_cnt_reg;

  // Frozen block stretches the access phase; a read whose setup cycle is frozen still completes, with the old prdata
  assign pready  = clk_en;
  assign wr_en   = clk_en & psel & penable & pwrite & pstrb[0];
  // Read word captured in setup so it already stands at the access edge
  assign rd_en   = clk_en & psel & ~penable & ~pwrite;
  assign pslverr = psel & penable & ~addr_hit;

  always_comb
  begin
    addr_hit = 1'b1;
    rd_word  = 8'h00;
    unique case (paddr)
      dmrt_pkg::ADDR_MON_SEL:    rd_word = mon_sel_reg;
      dmrt_pkg::ADDR_OPEN_QUEUE: rd_word = open_queue_reg;
      dmrt_pkg::ADDR_SAMPLE_MON: rd_word = sample_cnt_reg;
      dmrt_pkg::ADDR_OVER_MON:   rd_word = over_cnt_reg;
      dmrt_pkg::ADDR_IDENT:      rd_word = {PART_CODE, SILICON_REV};
      default:                   addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      prdata <= {24'h00_0000, rd_word};
  end

  // ----------------------------------------------------------------
  // Selector and queue registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      mon_sel_reg <= dmrt_pkg::MON_SEL_RESET;
    else if (wr_en && paddr == dmrt_pkg::ADDR_MON_SEL)
      mon_sel_reg <= {2'b00, pwdata[5:0]};
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      open_queue_reg <= dmrt_pkg::OPEN_Q_RESET;
    else if (wr_en && paddr == dmrt_pkg::ADDR_OPEN_QUEUE)
      open_queue_reg <= pwdata[7:0];
  end

  // Codes go straight to the analog mux; all eight are legal
  assign channel7_monitor_select = mon_sel_reg[dmrt_pkg::CH7_SEL_LSB +: 3];
  assign channel8_monitor_select = mon_sel_reg[dmrt_pkg::CH8_SEL_LSB +: 3];

  // ----------------------------------------------------------------
  // Open-circuit detection control
  // ----------------------------------------------------------------
  logic [7:0] unchanged_cnt_reg;
  logic       unchanged_sync1_reg;
  logic       unchanged_sync2_reg;

  always_comb
  begin
    if (open_queue_reg == dmrt_pkg::OPEN_Q_RESET)
      open_detect_mode = dmrt_pkg::DMRT_OPEN_OFF;
    else if (open_queue_reg == dmrt_pkg::OPEN_Q_MANUAL)
      open_detect_mode = dmrt_pkg::DMRT_OPEN_MANUAL;
    else
      open_detect_mode = dmrt_pkg::DMRT_OPEN_AUTO;
  end

  // Conversion strobe comes from the converter domain
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      unchanged_sync1_reg <= 1'b0;
      unchanged_sync2_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      unchanged_sync1_reg <= code_unchanged;
      unchanged_sync2_reg <= unchanged_sync1_reg;
    end
  end

  // Counts conversions with no code change; any change restarts the run
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      unchanged_cnt_reg  <= 8'h00;
      common_mode_switch <= 1'b0;
    end
    else if (clk_en)
    begin
      common_mode_switch <= 1'b0;
      if (open_detect_mode != dmrt_pkg::DMRT_OPEN_AUTO || !unchanged_sync2_reg)
        unchanged_cnt_reg <= 8'h00;
      else if (unchanged_cnt_reg + 8'h01 >= open_queue_reg)
      begin
        unchanged_cnt_reg  <= 8'h00;
        common_mode_switch <= 1'b1;
      end
      else
        unchanged_cnt_reg <= unchanged_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Clock monitors, one per sampled clock
  // ----------------------------------------------------------------
  logic [1:0] mon_pin;
  logic [7:0] mon_cnt [2];

  assign mon_pin      = {oversample_clk_pin, sample_clk_pin};
  assign sample_cnt_reg = mon_cnt[0];
  assign over_cnt_reg   = mon_cnt[1];

  // Monitored clocks are seen at rates up to half of ref_clk
  for (genvar g = 0; g < 2; g++)
  begin : g_mon
    logic       sync1_reg;
    logic       sync2_reg;
    logic       prev_reg;
    logic [5:0] prescale_reg;
    logic [7:0] count_reg;

    always_ff @(posedge ref_clk)
    begin
      if (!rst_b)
      begin
        sync1_reg    <= 1'b0;
        sync2_reg    <= 1'b0;
        prev_reg     <= 1'b0;
        prescale_reg <= 6'h00;
        count_reg    <= dmrt_pkg::CLK_MON_RESET;
      end
      else if (clk_en)
      begin
        sync1_reg <= mon_pin[g];
        sync2_reg <= sync1_reg;
        prev_reg  <= sync2_reg;
        if (sync2_reg && !prev_reg)
        begin
          prescale_reg <= prescale_reg + 6'h01;
          if (prescale_reg == dmrt_pkg::PRESCALE_LAST)
            count_reg <= count_reg + 8'h01;
        end
      end
    end
    assign mon_cnt[g] = count_reg;
  end

endmodule
`default_nettype wire

// ===== dv/dmrt_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module dmrt_regs_assertions #(
  parameter logic [3:0] PART_CODE   = 4'hA,
  parameter logic [3:0] SILICON_REV = 4'h5
) (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  channel7_monitor_select,
  input wire logic [2:0]  channel8_monitor_select,
  input wire logic [1:0]  open_detect_mode,
  input wire logic        common_mode_switch
);
  // ----------------------------------------------------------------
  // Decoded accesses
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [31:0] wd_q;
  wire logic acc = psel & penable & clk_en;
  wire logic wr = acc & pwrite & pstrb[0];
  wire logic rd = acc & ~pwrite;
  wire logic mapped = (paddr >= dmrt_pkg::ADDR_MON_SEL) && (paddr <= dmrt_pkg::ADDR_IDENT)
    && (paddr[1:0] == 2'h0);
  always_ff @(posedge ref_clk) wd_q <= pwdata;
  a_ch7_write: assert property (wr && paddr == dmrt_pkg::ADDR_MON_SEL
    |=> channel7_monitor_select == wd_q[2:0]) else $error("ch7 select not written");
  a_ch8_write: assert property (wr && paddr == dmrt_pkg::ADDR_MON_SEL
    |=> channel8_monitor_select == wd_q[5:3]) else $error("ch8 select not written");
  a_sel_hold: assert property (!(wr && paddr == dmrt_pkg::ADDR_MON_SEL)
    |=> $stable(channel7_monitor_select) && $stable(channel8_monitor_select))
    else $error("selector changed without write");
  a_queue_mode: assert property (wr && paddr == dmrt_pkg::ADDR_OPEN_QUEUE |=>
    open_detect_mode == (wd_q[7:0] == 8'h00 ? 2'h0 : wd_q[7:0] == 8'h01 ? 2'h1 : 2'h3))
    else $error("detect mode wrong");
  a_no_auto: assert property (open_detect_mode != 2'h3 && $past(open_detect_mode) != 2'h3
    |-> !common_mode_switch) else $error("switch outside auto mode");
  a_err_map: assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error wrong");
  a_ident_read: assert property (rd && paddr == dmrt_pkg::ADDR_IDENT
    |=> prdata == {24'h0, PART_CODE, SILICON_REV}) else $error("ident read wrong");
  a_sel_read: assert property (rd && paddr == dmrt_pkg::ADDR_MON_SEL |=> prdata ==
    {26'h0, $past(channel8_monitor_select), $past(channel7_monitor_select)})
    else $error("select read wrong");
  a_unmap_read: assert property (rd && !mapped |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_ready_en: assert property (pready == clk_en)
    else $error("ready not following enable");
endmodule
bind dmrt_regs dmrt_regs_assertions #(.PART_CODE(PART_CODE), .SILICON_REV(SILICON_REV)) u_chk (
  .ref_clk, .rst_b, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .channel7_monitor_select, .channel8_monitor_select, .open_detect_mode,
  .common_mode_switch);
`default_nettype wire

// ===== dv/test_diag_monitor_register_tail.sv
`timescale 1ns/10ps
`default_nettype none
module test_diag_monitor_register_tail;
  logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, common_mode_switch;
  logic        sample_clk_pin, oversample_clk_pin, code_unchanged, clk_en;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  ch7, ch8;
  logic [1:0]  mode;
  logic [7:0]  mdl [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hC2};
  int          miscompares = 0, samples_checked = 0, seed = 26, pulses = 0, es = 0, eo = 0, i;
  // Arbitrary identity values
  dmrt_regs #(.PART_CODE(4'hC), .SILICON_REV(4'h2)) u_dmrt_regs (.ref_clk, .rst_b,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready,
    .pslverr, .sample_clk_pin, .oversample_clk_pin, .code_unchanged, .common_mode_switch,
    .channel7_monitor_select(ch7), .channel8_monitor_select(ch8), .open_detect_mode(mode));
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) pulses <= pulses + int'(common_mode_switch === 1'b1);
  // ----------------------------------------------------------------
  // Bus and model tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    // Read data is taken at the completing edge itself
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
    if (idx == dmrt_pkg::IDX_MON_SEL) mdl[0] = d[7:0] & 8'h3F;
    if (idx == dmrt_pkg::IDX_OPEN_QUEUE) mdl[1] = d[7:0];
  endtask
  task automatic rchk(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0);
    check(rd, {24'h0, (idx - 8'h2B) < 8'h05 ? mdl[idx - 8'h2B] : 8'h00});
  endtask
  task automatic sweep;
    for (int k = 0; k < 6; k++) rchk(8'h2B + 8'(k));
  endtask
  task automatic clocks(input int ns, input int no, input bit frz = 1'b0);
    for (int k = 0; k < 2 * (ns > no ? ns : no); k++)
    begin
      if (k < 2 * ns) sample_clk_pin <= ~sample_clk_pin;
      if (k < 2 * no) oversample_clk_pin <= ~oversample_clk_pin;
      @(posedge ref_clk);
    end
    if (!frz)
    begin
      es += ns;
      eo += no;
    end
    mdl[2] = 8'(es / 64);
    mdl[3] = 8'(eo / 64);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic hold(input logic [7:0] q, input int n, input int want);
    int p0;
    wr(dmrt_pkg::IDX_OPEN_QUEUE, {24'h0, q});
    rchk(dmrt_pkg::IDX_OPEN_QUEUE);
    p0 = pulses;
    if (n > 0)
    begin
      code_unchanged <= 1'b1;
      repeat (n) @(posedge ref_clk);
      code_unchanged <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    check(32'(pulses - p0 > 0), 32'(want));
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, rst_b} = '0;
    {sample_clk_pin, oversample_clk_pin, code_unchanged} = '0;
    clk_en = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    sweep();
    for (i = 0; i < 8; i++)
    begin
      wr(dmrt_pkg::IDX_MON_SEL, ($random(seed) & 32'hFFFF_FFC0) | {26'h0, 3'(7 - i), 3'(i)});
      rchk(dmrt_pkg::IDX_MON_SEL);
    end
    for (i = 0; i < 4; i++) wr(8'h2D + 8'(i), $random(seed));
    sweep();
    clocks(64 * 3, 64 * 2);
    sweep();
    clk_en <= 1'b0;
    clocks(64, 64, 1'b1);
    clk_en <= 1'b1;
    sweep();
    clocks(64 * 256 + 64, 63);
    sweep();
    hold(8'h00, 20, 0);
    hold(8'h01, 20, 0);
    for (i = 0; i < 4; i++)
    begin
      hold(8'(2 + ($random(seed) & 15)), 0, 0);
      hold(mdl[1], mdl[1] - 1, 0);
      hold(mdl[1], mdl[1] + 3, 1);
    end
    give_verdict();
  end
  initial
  begin
    #3_000_000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
